// >>> src/seq_clk_pkg.sv
// constants for the sequencing and clock configuration bank
// assumes a single system clock that stands in for the crystal
package seq_clk_pkg;
  // register offsets
  localparam logic [7:0] ADDR_SEQ_CTRL  = 8'h03;
  localparam logic [7:0] ADDR_FREQ_HIGH = 8'h04;
  localparam logic [7:0] ADDR_FREQ_MID  = 8'h05;
  localparam logic [7:0] ADDR_FREQ_LOW  = 8'h06;
  localparam logic [7:0] ADDR_CLK_DIV   = 8'h07;
  // reset values
  localparam logic [7:0] RST_SEQ_CTRL  = 8'h8A;
  localparam logic [7:0] RST_FREQ_HIGH = 8'h83;
  localparam logic [7:0] RST_FREQ_MID  = 8'hB1;
  localparam logic [7:0] RST_FREQ_LOW  = 8'hF9;
  localparam logic [7:0] RST_CLK_DIV   = 8'h50;
  // field positions
  localparam int SEQ_TRIG_BIT  = 7;
  localparam int SEQ_RXW_LSB   = 4;
  localparam int SEQ_CSW_LSB   = 0;
  localparam int LOW_DITH_BIT  = 0;
  localparam int CLK_REF_LSB   = 5;
  localparam int CLK_DIV1_LSB  = 2;
  localparam int CLK_DIV2_LSB  = 0;
  // power-down mode that enables data-pin triggering
  localparam logic [1:0] POWER_DOWN_MODE_SEQ = 2'h3;
  // receive settle code meaning no wait
  localparam logic [2:0] RX_WAIT_NONE = 3'h7;
  // symbol is this many modem clock periods
  localparam logic [3:0] SYMBOL_DIV = 4'h8;
  // modem divider 1 in half units (2.5 -> 5)
  localparam logic [7:0] DIV1_HALF_0 = 8'h05;
  localparam logic [7:0] DIV1_HALF_1 = 8'h06;
  localparam logic [7:0] DIV1_HALF_2 = 8'h08;
  localparam logic [7:0] DIV1_HALF_3 = 8'h0F;
  localparam logic [7:0] DIV1_HALF_4 = 8'h19;
  localparam logic [7:0] DIV1_HALF_5 = 8'h50;
  localparam logic [7:0] DIV1_HALF_6 = 8'h60;
  localparam logic [7:0] DIV1_HALF_7 = 8'h80;
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_LOCK, ST_SETTLE, ST_SENSE, ST_DONE} seq_state_t;
endpackage

// >>> src/frac_divider.sv
// fractional clock divider producing one-cycle ticks
// divides the input tick stream by a ratio given in half units
`timescale 1ns/1ps
`default_nettype none
module frac_divider
  import seq_clk_pkg::*;
#(
  parameter int RATIO_W = 12
)(
  // clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_rst_n,
  // tick input and ratio
  input  wire logic               i_tick,
  input  wire logic [RATIO_W-1:0] i_half_ratio,
  // divided tick
  output logic                    o_tick
);
  logic [RATIO_W:0] acc_ff;   // accumulated half units
  logic [RATIO_W:0] nxt_acc;
  logic             tick_ff;
  logic             nxt_tick;

  // each input tick adds two halves; output fires when ratio reached
  always_comb
  begin
    nxt_acc  = acc_ff;
    nxt_tick = 1'b0;
    if (i_tick)
    begin
      if ((acc_ff + (RATIO_W+1)'(2)) >= {1'b0, i_half_ratio})
      begin
        // keep remainder so half ratios average out
        nxt_acc  = acc_ff + (RATIO_W+1)'(2) - {1'b0, i_half_ratio};
        nxt_tick = 1'b1;
      end
      else
      begin
        nxt_acc = acc_ff + (RATIO_W+1)'(2);
      end
    end
  end

  // register state
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      acc_ff  <= nxt_acc;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;
endmodule // frac_divider
`default_nettype wire

// >>> src/seq_clk_cfg.sv
// sequencing and clock configuration register bank with sequencer
// assumes i_sys_clk is the crystal; converter and filter clocks are
// given as one-cycle enables on the same clock
// Function
// - select trigger set: select falling edge starts
// - trigger clear: select ignored, data pin instead
// - data pin needs split, trigger clear, mode 3
// - settle codes 0-6 wait 32..256 converter periods
// - settle code 7 means no wait
// - sense window codes wait 20..72 filter periods
// - synth word built from three registers
// - low register bit zero enables dithering
// - reference divisor code 1 /2, 7 /8
// - first modem divider from 2.5 to 64
// - second modem divider 1,2,4,8
// - modem clock is reference over product
// - symbol rate is modem clock over eight
`timescale 1ns/1ps
`default_nettype none
module seq_clk_cfg
  import seq_clk_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // register port
  input  wire logic        i_reg_wr,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic [7:0]       o_reg_rdata,
  // pins from host
  input  wire logic        i_select_pin,
  input  wire logic        i_data_io_pin,
  // neighbouring configuration bits
  input  wire logic        i_split_data_pins,
  input  wire logic [1:0]  i_power_down_mode,
  // analog status and timebase enables
  input  wire logic        i_synth_lock,
  input  wire logic        i_carrier_sense,
  input  wire logic        i_adc_clk_tick,
  input  wire logic        i_filter_clk_tick,
  // sequencer outputs
  output logic             o_seq_start,
  output logic             o_rx_power_up,
  output logic             o_seq_power_down,
  // synthesizer and clock outputs
  output logic [22:0]      o_synth_word_a,
  output logic             o_synth_a_dither,
  output logic             o_ref_tick,
  output logic             o_modem_tick,
  output logic             o_symbol_tick
);
  // registers
  logic [7:0] seq_ctrl_ff;
  logic [7:0] freq_high_ff;
  logic [7:0] freq_mid_ff;
  logic [7:0] freq_low_ff;
  logic [7:0] clk_div_ff;
  logic [7:0] nxt_seq_ctrl;
  logic [7:0] nxt_freq_high;
  logic [7:0] nxt_freq_mid;
  logic [7:0] nxt_freq_low;
  logic [7:0] nxt_clk_div;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // converter wait for a settle code
  function automatic logic [8:0] rx_wait_len(input logic [2:0] code);
    case (code)
      3'h0:    rx_wait_len = 9'd32;
      3'h1:    rx_wait_len = 9'd44;
      3'h2:    rx_wait_len = 9'd64;
      3'h3:    rx_wait_len = 9'd88;
      3'h4:    rx_wait_len = 9'd128;
      3'h5:    rx_wait_len = 9'd176;
      3'h6:    rx_wait_len = 9'd256;
      default: rx_wait_len = 9'd0;
    endcase
  endfunction

  // filter periods for a sense window code
  function automatic logic [8:0] cs_wait_len(input logic [3:0] code);
    if (code < 4'h7)
      cs_wait_len = 9'd20 + {4'h0, code, 1'b0};
    else if (code < 4'hF)
      cs_wait_len = 9'd36 + {3'h0, code - 4'h7, 2'b00};
    else
      cs_wait_len = 9'd72;
  endfunction

  // register writes and read mux
  always_comb
  begin
    nxt_seq_ctrl  = seq_ctrl_ff;
    nxt_freq_high = freq_high_ff;
    nxt_freq_mid  = freq_mid_ff;
    nxt_freq_low  = freq_low_ff;
    nxt_clk_div   = clk_div_ff;
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        ADDR_SEQ_CTRL:  nxt_seq_ctrl  = i_reg_wdata;
        ADDR_FREQ_HIGH: nxt_freq_high = i_reg_wdata;
        ADDR_FREQ_MID:  nxt_freq_mid  = i_reg_wdata;
        ADDR_FREQ_LOW:  nxt_freq_low  = i_reg_wdata;
        ADDR_CLK_DIV:   nxt_clk_div   = i_reg_wdata;
        default:        ; // other addresses belong elsewhere
      endcase
    end
    case (i_reg_addr)
      ADDR_SEQ_CTRL:  nxt_rdata = seq_ctrl_ff;
      ADDR_FREQ_HIGH: nxt_rdata = freq_high_ff;
      ADDR_FREQ_MID:  nxt_rdata = freq_mid_ff;
      ADDR_FREQ_LOW:  nxt_rdata = freq_low_ff;
      ADDR_CLK_DIV:   nxt_rdata = clk_div_ff;
      default:        nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seq_ctrl_ff  <= RST_SEQ_CTRL;
      freq_high_ff <= RST_FREQ_HIGH;
      freq_mid_ff  <= RST_FREQ_MID;
      freq_low_ff  <= RST_FREQ_LOW;
      clk_div_ff   <= RST_CLK_DIV;
      rdata_ff     <= 8'h00;
    end
    else
    begin
      seq_ctrl_ff  <= nxt_seq_ctrl;
      freq_high_ff <= nxt_freq_high;
      freq_mid_ff  <= nxt_freq_mid;
      freq_low_ff  <= nxt_freq_low;
      clk_div_ff   <= nxt_clk_div;
      rdata_ff     <= nxt_rdata;
    end
  end

  assign o_reg_rdata = rdata_ff;

  // pin synchronisers; stage one feeds only stage two
  logic sel_s1_ff, sel_s2_ff, sel_d_ff;
  logic dio_s1_ff, dio_s2_ff, dio_d_ff;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // idle high so release does not fake an edge
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
      sel_d_ff  <= 1'b1;
      dio_s1_ff <= 1'b1;
      dio_s2_ff <= 1'b1;
      dio_d_ff  <= 1'b1;
    end
    else
    begin
      sel_s1_ff <= i_select_pin;
      sel_s2_ff <= sel_s1_ff;
      sel_d_ff  <= sel_s2_ff;
      dio_s1_ff <= i_data_io_pin;
      dio_s2_ff <= dio_s1_ff;
      dio_d_ff  <= dio_s2_ff;
    end
  end

  // trigger selection
  logic sel_fall;
  logic dio_fall;
  logic trig_sel;
  logic seq_trigger;
  assign sel_fall = sel_d_ff & ~sel_s2_ff;
  assign dio_fall = dio_d_ff & ~dio_s2_ff;
  assign trig_sel = seq_ctrl_ff[SEQ_TRIG_BIT];
  assign seq_trigger = (trig_sel & sel_fall)
                     | (~trig_sel & dio_fall & i_split_data_pins
                        & (i_power_down_mode == POWER_DOWN_MODE_SEQ));

  // power-up sequencer
  seq_state_t state_ff, nxt_state;
  logic [8:0] cnt_ff, nxt_cnt;
  logic       start_ff, nxt_start;
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_start = 1'b0;
    case (state_ff)
      ST_IDLE, ST_DONE:
      begin
        // a new trigger restarts even after a finished window
        if (seq_trigger)
        begin
          nxt_state = ST_LOCK;
          nxt_start = 1'b1;
        end
      end
      ST_LOCK:
      begin
        if (i_synth_lock)
        begin
          nxt_cnt = rx_wait_len(seq_ctrl_ff[SEQ_RXW_LSB +: 3]);
          if (seq_ctrl_ff[SEQ_RXW_LSB +: 3] == RX_WAIT_NONE)
          begin
            nxt_state = ST_SENSE;
            nxt_cnt   = cs_wait_len(seq_ctrl_ff[SEQ_CSW_LSB +: 4]);
          end
          else
            nxt_state = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        // count converter periods
        if (i_adc_clk_tick)
        begin
          if (cnt_ff <= 9'd1)
          begin
            nxt_state = ST_SENSE;
            nxt_cnt   = cs_wait_len(seq_ctrl_ff[SEQ_CSW_LSB +: 4]);
          end
          else
            nxt_cnt = cnt_ff - 9'd1;
        end
      end
      ST_SENSE:
      begin
        // carrier found ends the window early without power down
        if (i_carrier_sense)
          nxt_state = ST_IDLE;
        else if (i_filter_clk_tick)
        begin
          if (cnt_ff <= 9'd1)
            nxt_state = ST_DONE;
          else
            nxt_cnt = cnt_ff - 9'd1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 9'd0;
      start_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      start_ff <= nxt_start;
    end
  end

  assign o_seq_start      = start_ff;
  assign o_rx_power_up    = (state_ff == ST_SENSE);
  assign o_seq_power_down = (state_ff == ST_DONE);

  // synth word and dither straight from the registers
  assign o_synth_word_a   = {freq_high_ff, freq_mid_ff, freq_low_ff[7:1]};
  assign o_synth_a_dither = freq_low_ff[LOW_DITH_BIT];

  // reference divider: ratio is code plus one, code 0 held as /2
  // the shared divider counts half units, so the whole ratio is doubled
  logic [2:0] ref_code;   // divisor field
  logic [3:0] ref_ratio;  // crystal cycles per reference tick
  assign ref_code  = clk_div_ff[CLK_REF_LSB +: 3];
  assign ref_ratio = (ref_code == 3'h0) ? 4'h2 : {1'b0, ref_code} + 4'h1;

  // reference ticks from every crystal cycle
  frac_divider #(.RATIO_W(12)) u_ref_div (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_tick       (1'b1),
    .i_half_ratio ({7'h00, ref_ratio, 1'b0}),
    .o_tick       (o_ref_tick)
  );

  // modem ratio in half units: first divider times second
  logic [7:0]  div1_half;
  logic [11:0] modem_half;
  always_comb
  begin
    case (clk_div_ff[CLK_DIV1_LSB +: 3])
      3'h0:    div1_half = DIV1_HALF_0;
      3'h1:    div1_half = DIV1_HALF_1;
      3'h2:    div1_half = DIV1_HALF_2;
      3'h3:    div1_half = DIV1_HALF_3;
      3'h4:    div1_half = DIV1_HALF_4;
      3'h5:    div1_half = DIV1_HALF_5;
      3'h6:    div1_half = DIV1_HALF_6;
      default: div1_half = DIV1_HALF_7;
    endcase
    // second divider is a power of two shift
    modem_half = {4'h0, div1_half} << clk_div_ff[CLK_DIV2_LSB +: 2];
  end

  frac_divider #(.RATIO_W(12)) u_modem_div (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_tick       (o_ref_tick),
    .i_half_ratio (modem_half),
    .o_tick       (o_modem_tick)
  );

  // symbol tick every eight modem ticks; a whole ratio leaves no remainder
  frac_divider #(.RATIO_W(12)) u_sym_div (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_tick       (o_modem_tick),
    .i_half_ratio ({7'h00, SYMBOL_DIV, 1'b0}),
    .o_tick       (o_symbol_tick)
  );
endmodule // seq_clk_cfg
`default_nettype wire

// >>> tb/seq_clk_cfg_asserts.sv
// checker for the sequencing and clock bank
// sees only the top ports; bound at the foot
`timescale 1ns/1ps
`default_nettype none
module seq_clk_cfg_asserts
  import seq_clk_pkg::*;
(
  // watched ports
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_select_pin,
  input wire logic        i_data_io_pin,
  input wire logic        i_split_data_pins,
  input wire logic [1:0]  i_power_down_mode,
  input wire logic        i_synth_lock,
  input wire logic        i_carrier_sense,
  input wire logic        o_seq_start,
  input wire logic        o_rx_power_up,
  input wire logic        o_seq_power_down,
  input wire logic [22:0] o_synth_word_a,
  input wire logic        o_synth_a_dither
);
  logic [7:0] seq_ff;  // shadow of the sequencing register
  logic [3:0] sel_ff;  // cycles since select was low
  logic [3:0] dat_ff;  // cycles since data pin was low
  // shadow and age counters, saturating so old edges fade
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      seq_ff <= RST_SEQ_CTRL;
      sel_ff <= 4'hF;
      dat_ff <= 4'hF;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == ADDR_SEQ_CTRL)
        seq_ff <= i_reg_wdata;
      sel_ff <= !i_select_pin ? 4'h0 : sel_ff + 4'(sel_ff != 4'hF);
      dat_ff <= !i_data_io_pin ? 4'h0 : dat_ff + 4'(dat_ff != 4'hF);
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // lock rising with a given settle code
  sequence s_lock7;
    $rose(i_synth_lock) && seq_ff[6:4] == RX_WAIT_NONE;
  endsequence
  sequence s_lock0;
    $rose(i_synth_lock) && seq_ff[6:4] == 3'h0;
  endsequence
  a_start_pulse: assert property (o_seq_start |=> !o_seq_start)
    else $error("start pulse too long");
  a_start_cause: assert property (o_seq_start |->
    (seq_ff[SEQ_TRIG_BIT] && sel_ff < 4'h8) || (!seq_ff[SEQ_TRIG_BIT] &&
    i_split_data_pins && i_power_down_mode == POWER_DOWN_MODE_SEQ && dat_ff < 4'h8))
    else $error("start without cause");
  a_word_high: assert property (i_reg_wr && i_reg_addr == ADDR_FREQ_HIGH
    |-> ##3 o_synth_word_a[22:15] == $past(i_reg_wdata, 3))
    else $error("word high byte wrong");
  a_word_low: assert property (i_reg_wr && i_reg_addr == ADDR_FREQ_LOW
    |-> ##3 {o_synth_word_a[6:0], o_synth_a_dither} == $past(i_reg_wdata, 3))
    else $error("word low bits wrong");
  a_settle_none: assert property (s_lock7 |-> ##[1:4] o_rx_power_up)
    else $error("no-wait code waited");
  a_settle_wait: assert property (s_lock0 |-> ##1 !o_rx_power_up [*8])
    else $error("settle wait skipped");
  a_expire_down: assert property ($fell(o_rx_power_up) &&
    !$past(i_carrier_sense) |-> ##[0:2] o_seq_power_down)
    else $error("no power down after window");
  a_down_stands: assert property ($fell(o_seq_power_down) |->
    (##[0:1] o_seq_start) or $past(o_seq_start))
    else $error("power down left without trigger");
endmodule // seq_clk_cfg_asserts
bind seq_clk_cfg seq_clk_cfg_asserts u_chk (.*);
`default_nettype wire

// >>> tb/host_pin_model.sv
// host side driver of the two trigger pins
// pins idle high; a fire holds one pin low long enough for the sync
`timescale 1ns/1ps
`default_nettype none
module host_pin_model
(
  // clock and pins
  input  wire logic i_sys_clk,
  output var logic  o_select_pin,
  output var logic  o_data_io_pin
);
  // idle high, so no false edge at start
  initial
  begin
    o_select_pin = 1'b1;
    o_data_io_pin = 1'b1;
  end
  // one falling edge on the chosen pin, driven at falling clock edges
  task automatic fire(input bit use_data);
    @(negedge i_sys_clk);
    if (use_data)
      o_data_io_pin = 1'b0;
    else
      o_select_pin = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    o_select_pin = 1'b1;
    o_data_io_pin = 1'b1;
  endtask
endmodule // host_pin_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the sequencing and clock bank
// host pin model drives the pins; converter/filter ticks every 4 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import seq_clk_pkg::*;
  logic        clk, rst_n, wr, lock, split, cs;
  logic [1:0]  pdm, tc;      // power-down mode, tick phase
  logic [7:0]  addr, wdata, rdata;
  logic        sel, data_io_pin, start, rxu, pdn, dith, reft, modt, symt;
  logic [22:0] word;
  int          err_count, n_tests, cyc, c, e;
  int st[8] = '{32, 44, 64, 88, 128, 176, 256, 0};
  int cw[16] = '{20, 22, 24, 26, 28, 30, 32, 36, 40, 44, 48, 52, 56, 60, 64, 72};
  int hr[8] = '{5, 6, 8, 15, 25, 80, 96, 128};  // first divider, half units
  logic [7:0] rv[5] = '{RST_SEQ_CTRL, 8'h83, 8'hB1, RST_FREQ_LOW, RST_CLK_DIV};
  host_pin_model u_host (.i_sys_clk(clk), .o_select_pin(sel), .o_data_io_pin(data_io_pin));
  seq_clk_cfg u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_select_pin(sel), .i_data_io_pin(data_io_pin), .i_split_data_pins(split),
    .i_power_down_mode(pdm), .i_synth_lock(lock), .i_carrier_sense(cs),
    .i_adc_clk_tick(tc == 2'h0), .i_filter_clk_tick(tc == 2'h2),
    .o_seq_start(start), .o_rx_power_up(rxu), .o_seq_power_down(pdn),
    .o_synth_word_a(word), .o_synth_a_dither(dith), .o_ref_tick(reft),
    .o_modem_tick(modt), .o_symbol_tick(symt));
  always #25 clk = ~clk;
  // tick phase and hang guard, well above the expected 30k cycles
  always @(negedge clk)
  begin
    tc <= tc + 2'h1;
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // read data is registered, valid one cycle after the address
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk(rdata === e, "read data");
  endtask
  // cycles spanning n ticks of ref (s=0), modem (s=1) or symbol (s=2)
  task automatic gap(input int s, input int n, output int k);
    int t;
    t = 0;
    k = 0;
    while ((s == 0 ? reft : s == 1 ? modt : symt) !== 1'b1 && k < 9000)
    begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (t < n && k < 20000)
    begin
      @(negedge clk);
      k++;
      if ((s == 0 ? reft : s == 1 ? modt : symt) === 1'b1)
        t++;
    end
  endtask
  // one trigger, then lock, settle and sense window timing
  task automatic seq(input bit dp, input bit ex, input int es, input int ew);
    int t;
    bit got;
    got = 0;
    fork
      u_host.fire(dp);
      repeat (12)
      begin
        @(negedge clk);
        got |= (start === 1'b1);
      end
    join
    chk(got == ex, "trigger");
    if (got)
    begin
      lock = 1'b1;
      t = 0;
      while (rxu !== 1'b1 && t < 1100)
      begin
        @(negedge clk);
        t++;
      end
      chk(t >= es - 5 && t <= es + 5, "settle time");
      t = 0;
      while (rxu === 1'b1 && t < 320)
      begin
        @(negedge clk);
        t++;
      end
      chk(t >= ew - 5 && t <= ew + 5, "sense window");
      chk(pdn === 1'b1, "power down");
      lock = 1'b0;
    end
  endtask
  task automatic trg(input logic [7:0] r, input logic sp, input logic [1:0] pm,
    input bit dp, input bit ex);
    wreg(ADDR_SEQ_CTRL, r);
    split = sp;
    pdm = pm;
    seq(dp, ex, 0, 80);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {clk, rst_n, wr, lock, split, cs, pdm, tc, addr, wdata, cyc} = '0;
    {err_count, n_tests} = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++)
      rreg(8'h03 + 8'(i), rv[i]);
    rreg(8'h08, 8'h00);
    wreg(ADDR_FREQ_HIGH, 8'h12);
    wreg(ADDR_FREQ_MID, 8'h34);
    wreg(ADDR_FREQ_LOW, 8'h57);
    repeat (3) @(negedge clk);
    chk(word === 23'h09_1A2B && dith === 1'b1, "word");
    wreg(ADDR_FREQ_LOW, 8'h56);
    repeat (3) @(negedge clk);
    chk(dith === 1'b0 && word === 23'h09_1A2B, "dither off");
    $display("test registers done");
    for (int r = 1; r < 8; r++)
    begin
      wreg(ADDR_CLK_DIV, {3'(r), 5'h00});
      gap(0, 1, c);
      gap(0, 1, c);
      chk(c == r + 1, "ref divide");
    end
    $display("test reference done");
    for (int d = 0; d < 11; d++)
    begin
      // fastest reference kept for every modem ratio
      wreg(ADDR_CLK_DIV, d < 8 ? {3'h1, 3'(d), 2'h0} : {6'h08, 2'(d - 7)});
      // two symbols span sixteen modem ticks; ref is /2 throughout
      e = d < 8 ? 16 * hr[d] : 80 << (d - 7);
      gap(2, 2, c);
      gap(2, 2, c);
      chk(c == e, "symbol");
      gap(1, 16, c);
      chk(c == e, "modem");
    end
    $display("test modem done");
    for (int w = 0; w < 8; w++)
    begin
      wreg(ADDR_SEQ_CTRL, {1'b1, 3'(w), 4'h0});
      seq(0, 1, 4 * st[w], 4 * cw[0]);
    end
    for (int k = 0; k < 16; k++)
    begin
      wreg(ADDR_SEQ_CTRL, {4'hF, 4'(k)});
      seq(0, 1, 0, 4 * cw[k]);
    end
    // carrier found mid window: receive drops early, no power down
    wreg(ADDR_SEQ_CTRL, 8'hFF);
    u_host.fire(0);
    lock = 1'b1;
    repeat (20) @(negedge clk);
    chk(rxu === 1'b1, "window open");
    cs = 1'b1;
    repeat (2) @(negedge clk);
    chk(rxu === 1'b0 && pdn === 1'b0, "carrier stop");
    cs = 1'b0;
    lock = 1'b0;
    $display("test sequencing done");
    trg(8'h70, 1'b1, 2'h3, 0, 0);
    trg(8'h70, 1'b1, 2'h3, 1, 1);
    trg(8'h70, 1'b0, 2'h3, 1, 0);
    trg(8'h70, 1'b1, 2'h2, 1, 0);
    trg(8'hF0, 1'b1, 2'h3, 1, 0);
    $display("test triggers done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
